/* slt_defines.svh */
`ifndef SLT_DEFINES_SVH
`define SLT_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SLT_OFF_MAXSPD 16'h0150
`define SLT_OFF_KP 16'h0208
`define SLT_OFF_KI 16'h0206
`define SLT_OFF_KF 16'h020e
`define SLT_OFF_MODE 16'h0240
`define SLT_OFF_INERTIA 16'h0300
`define SLT_OFF_STIFF 16'h0304
`define SLT_OFF_POSGAIN 16'h0308
`define SLT_OFF_LPF 16'h030c
`define SLT_OFF_COMP 16'h0310
`define SLT_OFF_STATUS 16'h0314
`define SLT_OFF_SPDOUT 16'h0318

// ****************************************************************
// Reset values
// ****************************************************************
`define SLT_RST_MAXSPD 32'h00000bb8
`define SLT_RST_KP 16'h01f4
`define SLT_RST_KI 16'h0064
`define SLT_RST_KF 16'h0000
`define SLT_RST_MODE 16'h0000
`define SLT_RST_INERTIA 16'h000a
`define SLT_RST_STIFF 16'h0050
`define SLT_RST_POSGAIN 16'h0023
`define SLT_RST_LPF 16'h0002
`define SLT_RST_COMP 16'h0000

// ****************************************************************
// Scaling and timing
// ****************************************************************
// Analog full scale: signed 16-bit code 32767 equals 10 V
`define SLT_FULL_SCALE_MV 10000
`define SLT_ADC_FULL 32'd32767
`define SLT_SAVE_MINUTES 30
`define SLT_CLK_MHZ 100
// Inertia estimator: stable tolerance, stable count in samples, range limit
`define SLT_STABLE_TOL 16'h0004
`define SLT_STABLE_CNT 8'h10
`define SLT_INERTIA_MAX 16'h0fa0

`endif

/* slt_pkg.sv */
package slt_pkg;

  typedef enum logic [1:0] {
    SLT_MANUAL = 2'h0,
    SLT_AUTO = 2'h1,
    SLT_SEMI = 2'h2
  } slt_mode_t;

  // Gains that the auto modes produce
  typedef struct packed {
    logic [15:0] pos_gain;
    logic [15:0] kp;
    logic [15:0] ki;
    logic [15:0] lpf;
    logic [15:0] comp;
  } slt_gains_t;

  // Classic Wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [15:0] adr;
    logic [31:0] dat;
  } slt_wb_req_t;

endpackage : slt_pkg

/* slt_inertia_est.sv */
`timescale 1ns/100ps
`include "slt_defines.svh"
// Inertia estimator: first-order tracking of a measured load sample
module slt_inertia_est
  import slt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [15:0] seed_i,
  input wire logic [15:0] sample_i,
  input wire logic sample_valid_i,
  output logic [15:0] inertia_o,
  output logic stable_o
);

  logic [15:0] est_q;
  logic [7:0] stable_cnt_q;
  logic [15:0] diff;

  assign diff = (sample_i > est_q) ? (sample_i - est_q) : (est_q - sample_i);

  // Estimate moves 1/8 of the way to each sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      est_q <= 16'h0000;
    end else if (restart_i) begin
      est_q <= seed_i;
    end else if (run_i && sample_valid_i) begin
      if (sample_i > est_q) begin
        est_q <= est_q + ((diff >> 3) | 16'h0001);
      end else if (sample_i < est_q) begin
        est_q <= est_q - ((diff >> 3) | 16'h0001);
      end
    end
  end

  // Stability: consecutive samples within tolerance
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      stable_cnt_q <= 8'h00;
    end else if (run_i && sample_valid_i) begin
      if (diff > `SLT_STABLE_TOL) begin
        stable_cnt_q <= 8'h00;
      end else if (stable_cnt_q != `SLT_STABLE_CNT) begin
        stable_cnt_q <= stable_cnt_q + 8'h01;
      end
    end
  end

  assign inertia_o = est_q;
  assign stable_o = (stable_cnt_q == `SLT_STABLE_CNT);

endmodule : slt_inertia_est

/* slt_speed_tune.sv */
`timescale 1ns/100ps
`include "slt_defines.svh"
module slt_speed_tune
  import slt_pkg::*;
#(
  parameter longint unsigned SAVE_CYCLES = 64'd60 * `SLT_SAVE_MINUTES * `SLT_CLK_MHZ * 64'd1000000
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic signed [15:0] analog_diff_i,
  input wire logic zero_speed_command_mode_i,
  input wire logic speed_select_low_i,
  input wire logic speed_select_high_i,
  input wire logic [31:0] preset_speed_i,
  input wire logic signed [31:0] speed_fb_i,
  input wire logic [15:0] load_sample_i,
  input wire logic load_valid_i,
  output logic signed [31:0] active_speed_command_o,
  output logic signed [47:0] speed_loop_out_o,
  output logic semi_auto_done_flag_o
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [31:0] max_analog_speed_limit_q;
  logic [15:0] speed_proportional_gain_q;
  logic [15:0] speed_integral_gain_q;
  logic [15:0] speed_feedforward_gain_q;
  logic [15:0] tuning_mode_selector_q;
  logic [15:0] inertia_ratio_q;
  logic [15:0] stiffness_bandwidth_setting_q;
  logic [15:0] position_gain_q;
  logic [15:0] resonance_lowpass_filter_q;
  logic [15:0] resonance_companion_param_q;
  logic semi_auto_done_flag_q;
  logic wb_ack_q;
  logic [31:0] wb_dat_q;
  slt_wb_req_t req;
  logic wr_stb;
  logic rd_stb;

  // Mode decode, used for current and previous mode
  function automatic slt_mode_t dec_mode(input logic [15:0] v);
    unique case (v)
      16'h0001: dec_mode = SLT_AUTO;
      16'h0002: dec_mode = SLT_SEMI;
      default: dec_mode = SLT_MANUAL;
    endcase
  endfunction : dec_mode

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : merge16

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};
  // Ack one cycle after the strobe, then drop for a cycle
  assign wr_stb = req.cyc && req.stb && req.we && !wb_ack_q;
  assign rd_stb = req.cyc && req.stb && !req.we && !wb_ack_q;

  // Bus ack: single cycle, every address answered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
    end else begin
      wb_ack_q <= req.cyc && req.stb && !wb_ack_q;
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  // ****************************************************************
  // Mode tracking and estimator
  // ****************************************************************
  slt_mode_t mode;
  slt_mode_t prev_mode_q;
  logic enter_semi;
  logic to_manual;
  logic est_run;
  logic [15:0] est_inertia;
  logic est_stable;
  logic out_of_range;
  logic [$clog2(SAVE_CYCLES+1)-1:0] save_cnt_q;
  logic save_tick;
  slt_gains_t auto_g;

  assign mode = dec_mode(tuning_mode_selector_q);
  assign enter_semi = (mode == SLT_SEMI) && (prev_mode_q != SLT_SEMI);
  assign to_manual = (mode == SLT_MANUAL) && (prev_mode_q != SLT_MANUAL);
  // raw samples watched too, since a settled estimate is frozen
  assign out_of_range = (est_inertia > `SLT_INERTIA_MAX) ||
                        (load_valid_i && (load_sample_i > `SLT_INERTIA_MAX));
  assign est_run = (mode == SLT_AUTO) || ((mode == SLT_SEMI) && !semi_auto_done_flag_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_mode_q <= SLT_MANUAL;
    end else begin
      prev_mode_q <= mode;
    end
  end

  slt_inertia_est u_est (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(est_run),
    .restart_i(enter_semi || ((mode == SLT_AUTO) && (prev_mode_q == SLT_MANUAL))),
    .seed_i(inertia_ratio_q),
    .sample_i(load_sample_i),
    .sample_valid_i(load_valid_i),
    .inertia_o(est_inertia),
    .stable_o(est_stable)
  );

  // 30-minute save timer in auto mode
  always_ff @(posedge clk_i) begin
    if (rst_i || mode != SLT_AUTO) begin
      save_cnt_q <= '0;
    end else if (save_tick) begin
      save_cnt_q <= '0;
    end else begin
      save_cnt_q <= save_cnt_q + 1'b1;
    end
  end
  assign save_tick = (mode == SLT_AUTO) && (save_cnt_q == ($bits(save_cnt_q))'(SAVE_CYCLES - 1));

  // gains from stiffness and inertia; low-pass is 1000 over bandwidth
  always_comb begin
    auto_g.kp = 16'((32'(stiffness_bandwidth_setting_q) * (32'(est_inertia) + 32'd10)) / 32'd10);
    auto_g.ki = stiffness_bandwidth_setting_q >> 1;
    auto_g.pos_gain = stiffness_bandwidth_setting_q >> 2;
    auto_g.lpf = 16'h03e8 / (stiffness_bandwidth_setting_q | 16'h0001);
    auto_g.comp = est_inertia >> 4;
  end

  // Semi-auto completion flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      semi_auto_done_flag_q <= 1'b0;
    end else if (mode != SLT_SEMI || enter_semi) begin
      semi_auto_done_flag_q <= 1'b0;
    end else if (out_of_range) begin
      semi_auto_done_flag_q <= 1'b0;
    end else if (est_stable) begin
      semi_auto_done_flag_q <= 1'b1;
    end
  end
  assign semi_auto_done_flag_o = semi_auto_done_flag_q;

  // ****************************************************************
  // Register writes and hardware updates
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      max_analog_speed_limit_q <= `SLT_RST_MAXSPD;
      speed_proportional_gain_q <= `SLT_RST_KP;
      speed_integral_gain_q <= `SLT_RST_KI;
      speed_feedforward_gain_q <= `SLT_RST_KF;
      tuning_mode_selector_q <= `SLT_RST_MODE;
      stiffness_bandwidth_setting_q <= `SLT_RST_STIFF;
      position_gain_q <= `SLT_RST_POSGAIN;
      resonance_lowpass_filter_q <= `SLT_RST_LPF;
      resonance_companion_param_q <= `SLT_RST_COMP;
    end else begin
      if (wr_stb) begin
        unique case (req.adr)
          `SLT_OFF_MAXSPD: begin
            for (int b = 0; b < 4; b++) begin
              if (req.sel[b]) begin
                max_analog_speed_limit_q[8*b +: 8] <= req.dat[8*b +: 8];
              end
            end
          end
          `SLT_OFF_KP: speed_proportional_gain_q <= merge16(speed_proportional_gain_q,
                                                            req.dat, req.sel);
          `SLT_OFF_KI: speed_integral_gain_q <= merge16(speed_integral_gain_q, req.dat, req.sel);
          `SLT_OFF_KF: speed_feedforward_gain_q <= merge16(speed_feedforward_gain_q,
                                                           req.dat, req.sel);
          `SLT_OFF_MODE: tuning_mode_selector_q <= merge16(tuning_mode_selector_q,
                                                           req.dat, req.sel);
          `SLT_OFF_STIFF: stiffness_bandwidth_setting_q <= merge16(stiffness_bandwidth_setting_q,
                                                                   req.dat, req.sel);
          `SLT_OFF_POSGAIN: position_gain_q <= merge16(position_gain_q, req.dat, req.sel);
          `SLT_OFF_LPF: resonance_lowpass_filter_q <= merge16(resonance_lowpass_filter_q,
                                                              req.dat, req.sel);
          `SLT_OFF_COMP: resonance_companion_param_q <= merge16(resonance_companion_param_q,
                                                                req.dat, req.sel);
          default: ;
        endcase
      end
      // Hardware update wins over a same-cycle software write
      if (to_manual) begin
        position_gain_q <= auto_g.pos_gain;
        speed_proportional_gain_q <= auto_g.kp;
        speed_integral_gain_q <= auto_g.ki;
        if (prev_mode_q == SLT_SEMI) begin
          resonance_lowpass_filter_q <= auto_g.lpf;
          resonance_companion_param_q <= auto_g.comp;
        end
      end
    end
  end

  // Inertia ratio: software write, or hardware save
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inertia_ratio_q <= `SLT_RST_INERTIA;
    end else if (to_manual || save_tick || (mode == SLT_SEMI && !enter_semi && est_stable &&
                 !semi_auto_done_flag_q && !out_of_range)) begin
      // store on leave, timed, on settle
      inertia_ratio_q <= est_inertia;
    end else if (wr_stb && req.adr == `SLT_OFF_INERTIA) begin
      inertia_ratio_q <= merge16(inertia_ratio_q, req.dat, req.sel);
    end
  end

  // ****************************************************************
  // Speed command and loop
  // ****************************************************************
  logic signed [31:0] scaled_cmd;
  logic signed [31:0] cmd_q;
  logic signed [31:0] err;
  logic signed [47:0] acc_q;
  logic signed [47:0] ff_term;
  logic signed [15:0] kp_eff;
  logic signed [15:0] ki_eff;

  // speed = max * input / full scale
  assign scaled_cmd = 32'((64'(signed'(analog_diff_i)) * $signed({1'b0, max_analog_speed_limit_q}))
                          / $signed({1'b0, `SLT_ADC_FULL}));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= 32'sh0;
    end else if (speed_select_low_i || speed_select_high_i) begin
      cmd_q <= signed'(preset_speed_i);
    end else if (zero_speed_command_mode_i) begin
      cmd_q <= 32'sh0;
    end else begin
      cmd_q <= scaled_cmd;
    end
  end
  assign active_speed_command_o = cmd_q;

  // user gains in manual, computed gains otherwise
  assign kp_eff = (mode == SLT_MANUAL) ? signed'(speed_proportional_gain_q) : signed'(auto_g.kp);
  assign ki_eff = (mode == SLT_MANUAL) ? signed'(speed_integral_gain_q) : signed'(auto_g.ki);
  assign err = cmd_q - speed_fb_i;
  assign ff_term = 48'((64'(cmd_q) * 64'(signed'(speed_feedforward_gain_q))) / 64'sd100);

  // Integral accumulator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= 48'sh0;
    end else begin
      acc_q <= acc_q + 48'(err);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_loop_out_o <= 48'sh0;
    end else begin
      speed_loop_out_o <= 48'(64'(kp_eff) * 64'(err) + 64'(ki_eff) * 64'(acc_q)) + ff_term;
    end
  end

  // Read mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_q <= 32'h0;
    end else if (rd_stb) begin
      unique case (req.adr)
        `SLT_OFF_MAXSPD: wb_dat_q <= max_analog_speed_limit_q;
        `SLT_OFF_KP: wb_dat_q <= {16'h0, speed_proportional_gain_q};
        `SLT_OFF_KI: wb_dat_q <= {16'h0, speed_integral_gain_q};
        `SLT_OFF_KF: wb_dat_q <= {16'h0, speed_feedforward_gain_q};
        `SLT_OFF_MODE: wb_dat_q <= {16'h0, tuning_mode_selector_q};
        `SLT_OFF_INERTIA: wb_dat_q <= {16'h0, inertia_ratio_q};
        `SLT_OFF_STIFF: wb_dat_q <= {16'h0, stiffness_bandwidth_setting_q};
        `SLT_OFF_POSGAIN: wb_dat_q <= {16'h0, position_gain_q};
        `SLT_OFF_LPF: wb_dat_q <= {16'h0, resonance_lowpass_filter_q};
        `SLT_OFF_COMP: wb_dat_q <= {16'h0, resonance_companion_param_q};
        `SLT_OFF_STATUS: wb_dat_q <= {31'h0, semi_auto_done_flag_q};
        `SLT_OFF_SPDOUT: wb_dat_q <= cmd_q;
        default: wb_dat_q <= 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_leave_auto;
    prev_mode_q == SLT_AUTO ##0 mode == SLT_MANUAL;
  endsequence

  a_zero_cmd_forced: assert property (@(posedge clk_i) disable iff (rst_i)
    zero_speed_command_mode_i && !speed_select_low_i && !speed_select_high_i |=> cmd_q == 0)
    else $error("zero speed mode did not zero the command");
  a_leave_auto_gains: assert property (@(posedge clk_i) disable iff (rst_i)
    s_leave_auto |=> speed_integral_gain_q == $past(auto_g.ki))
    else $error("integral gain not overwritten on leaving auto");
  a_manual_no_est: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == SLT_MANUAL |=> est_inertia == $past(est_inertia))
    else $error("estimate moved in manual");
  a_semi_done_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == SLT_SEMI && out_of_range && prev_mode_q == SLT_SEMI |=> !semi_auto_done_flag_q)
    else $error("done flag not cleared out of range");
  a_semi_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    enter_semi |=> !semi_auto_done_flag_q)
    else $error("entering semi-auto left done flag set");
  a_inertia_store: assert property (@(posedge clk_i) disable iff (rst_i)
    to_manual |=> inertia_ratio_q == $past(est_inertia))
    else $error("inertia not stored on return to manual");
  a_bus_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_done_stops_est: assert property (@(posedge clk_i) disable iff (rst_i)
    semi_auto_done_flag_q && mode == SLT_SEMI |=> est_inertia == $past(est_inertia))
    else $error("estimation not stopped when done");

endmodule : slt_speed_tune

/* slt_load_model.sv */
`timescale 1ns/100ps
// ****************************************************************
// Load sensor model: inertia samples at a steady pace
// ****************************************************************
module slt_load_model
  import slt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] level_i,
  output logic [15:0] load_sample_o,
  output logic load_valid_o
);
  logic [1:0] pace_q;
  logic [15:0] last_q;

  // One sample every fourth cycle, so the estimator sees gaps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pace_q <= 2'h0;
    end else begin
      pace_q <= pace_q + 2'h1;
    end
  end

  // Remember the last value put on the sample bus
  always_ff @(posedge clk_i) begin
    if (pace_q == 2'h3) begin
      last_q <= level_i;
    end
  end

  // Data outside a valid pulse is scrambled, never a stale copy
  assign load_valid_o = !rst_i && (pace_q == 2'h3);
  assign load_sample_o = load_valid_o ? level_i : ~last_q;
endmodule : slt_load_model

/* slt_tb.sv */
`timescale 1ns/100ps
`include "slt_defines.svh"
module testbench
  import slt_pkg::*;
;
  localparam int STF = `SLT_RST_STIFF;
  logic clk_i, rst_i, cyc, stb, we, ack, zero_md, sel_lo, sel_hi, flag, lvalid;
  logic [3:0] sel;
  logic [15:0] adr, lsamp, level;
  logic signed [15:0] analog;
  logic [31:0] wdat, rdat, dat_o, preset;
  logic signed [31:0] fb, cmd;
  logic signed [47:0] lout, prev;
  int bad_count, n_checks;

  // ****************************************************************
  // Clock, design and load model
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  slt_speed_tune #(.SAVE_CYCLES(50)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .analog_diff_i(analog),
    .zero_speed_command_mode_i(zero_md), .speed_select_low_i(sel_lo),
    .speed_select_high_i(sel_hi), .preset_speed_i(preset), .speed_fb_i(fb),
    .load_sample_i(lsamp), .load_valid_i(lvalid), .active_speed_command_o(cmd),
    .speed_loop_out_o(lout), .semi_auto_done_flag_o(flag));

  slt_load_model model (.clk_i(clk_i), .rst_i(rst_i), .level_i(level),
    .load_sample_o(lsamp), .load_valid_o(lvalid));

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; the request is held until ack is sampled
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    for (i = 0; i < 64 && ack !== 1'b1; i++) @(posedge clk_i);
    if (i == 64) begin
      bad_count++;
      stop_test();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(48'(rdat), 48'(e));
  endtask : rd

  // Drive the command inputs, let them settle, look at the command
  task automatic cmd_chk(input logic signed [15:0] a, input logic z, input logic lo,
                         input logic hi, input logic signed [31:0] e);
    @(posedge clk_i);
    analog <= a;
    zero_md <= z;
    sel_lo <= lo;
    sel_hi <= hi;
    repeat (3) @(negedge clk_i);
    chk(cmd, e);
  endtask : cmd_chk

  // Bounded wait on the done flag; a timeout shows as a mismatch
  task automatic wait_flag(input logic v);
    int i;
    for (i = 0; i < 3000 && flag !== v; i++) @(negedge clk_i);
    chk(48'(flag), 48'(v));
  endtask : wait_flag

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {cyc, stb, we, zero_md, sel_lo, sel_hi} = 6'h00;
    sel = 4'h0;
    adr = 16'h0000;
    wdat = 32'h0;
    analog = 16'sh0000;
    preset = 32'h000004d2;
    fb = 32'sh0;
    level = 16'h0014;
    bad_count = 0;
    n_checks = 0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, unmapped place reads zero
    rd(`SLT_OFF_KP, 32'(`SLT_RST_KP));
    rd(`SLT_OFF_KI, 32'(`SLT_RST_KI));
    rd(`SLT_OFF_KF, 32'(`SLT_RST_KF));
    rd(`SLT_OFF_MODE, 32'(`SLT_RST_MODE));
    rd(`SLT_OFF_MAXSPD, `SLT_RST_MAXSPD);
    rd(16'h0400, 32'h0);
    // Analog scaling against a limit that differs from reset
    wb(1'b1, `SLT_OFF_MAXSPD, 32'd2000);
    cmd_chk(16'sd32767, 1'b0, 1'b0, 1'b0, 32'sd2000);
    cmd_chk(16'sd16384, 1'b0, 1'b0, 1'b0, 32'sd1000);
    cmd_chk(-16'sd32767, 1'b0, 1'b0, 1'b0, -32'sd2000);
    cmd_chk(16'sd32767, 1'b1, 1'b0, 1'b0, 32'sd0);
    cmd_chk(16'sd32767, 1'b0, 1'b1, 1'b0, 32'sd1234);
    cmd_chk(16'sd32767, 1'b0, 1'b0, 1'b1, 32'sd1234);
    cmd_chk(16'sd32767, 1'b0, 1'b0, 1'b0, 32'sd2000);
    // Loop terms one at a time: command 1234 against feedback 1174
    cmd_chk(16'sd0, 1'b0, 1'b1, 1'b0, 32'sd1234);
    rd(`SLT_OFF_SPDOUT, 32'd1234);
    @(posedge clk_i);
    fb <= 32'sd1174;
    wb(1'b1, `SLT_OFF_KP, 32'd2);
    wb(1'b1, `SLT_OFF_KI, 32'd0);
    repeat (4) @(negedge clk_i);
    chk(lout, 48'sd120);
    wb(1'b1, `SLT_OFF_KP, 32'd0);
    wb(1'b1, `SLT_OFF_KF, 32'd100);
    repeat (4) @(negedge clk_i);
    chk(lout, 48'sd1234);
    wb(1'b1, `SLT_OFF_KF, 32'd0);
    wb(1'b1, `SLT_OFF_KI, 32'd1);
    repeat (4) @(negedge clk_i);
    prev = lout;
    @(negedge clk_i);
    chk(lout - prev, 48'sd60);
    rd(`SLT_OFF_KP, 32'd0);
    // Semi-auto settles from a seed above the load, then hands gains back
    wb(1'b1, `SLT_OFF_INERTIA, 32'd24);
    wb(1'b1, `SLT_OFF_MODE, 32'd2);
    wait_flag(1'b1);
    rd(`SLT_OFF_STATUS, 32'h1);
    rd(`SLT_OFF_INERTIA, 32'd20);
    wb(1'b1, `SLT_OFF_MODE, 32'd0);
    rd(`SLT_OFF_KP, 32'(STF * 30 / 10));
    rd(`SLT_OFF_KI, 32'(STF / 2));
    rd(`SLT_OFF_POSGAIN, 32'(STF / 4));
    rd(`SLT_OFF_LPF, 32'(1000 / STF));
    rd(`SLT_OFF_COMP, 32'd1);
    // Auto overwrites a stale inertia on its periodic save
    wb(1'b1, `SLT_OFF_LPF, 32'd7);
    wb(1'b1, `SLT_OFF_COMP, 32'd9);
    wb(1'b1, `SLT_OFF_MODE, 32'd1);
    wb(1'b1, `SLT_OFF_INERTIA, 32'd99);
    repeat (200) @(posedge clk_i);
    rd(`SLT_OFF_INERTIA, 32'd20);
    wb(1'b1, `SLT_OFF_MODE, 32'd0);
    rd(`SLT_OFF_KP, 32'(STF * 30 / 10));
    rd(`SLT_OFF_POSGAIN, 32'(STF / 4));
    rd(`SLT_OFF_LPF, 32'd7);
    rd(`SLT_OFF_COMP, 32'd9);
    // Out of range load clears the flag again
    wb(1'b1, `SLT_OFF_MODE, 32'd2);
    wait_flag(1'b1);
    @(posedge clk_i);
    level <= 16'd5000;
    wait_flag(1'b0);
    stop_test();
  end
endmodule : testbench
